/* shared/frb_pkg.sv */
package frb_pkg;

	// ------------------------------------------------------------
	// register map (word offsets on the plain port)
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_CTRL     = 4'h0;  // arm / disarm / policy
	localparam logic [3:0] OFF_RTW_LOAD = 4'h1;  // reset-time timeout ticks
	localparam logic [3:0] OFF_SCW_LOAD = 4'h2;  // completion timeout ticks
	localparam logic [3:0] OFF_OSW_LOAD = 4'h3;  // os load timeout ticks
	localparam logic [3:0] OFF_CMD      = 4'h4;  // firmware commands
	localparam logic [3:0] OFF_STATUS   = 4'h5;  // boot cpu, flags
	localparam logic [3:0] OFF_SLOTS    = 4'h6;  // per-slot states
	localparam logic [3:0] OFF_HIST     = 4'h7;  // failure history
	localparam logic [3:0] OFF_LOG      = 4'h8;  // self-logged event

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_SCW_ARM  = 0;   // completion watchdog armed
	localparam int CTRL_OSW_ARM  = 1;   // os load watchdog armed
	localparam int CTRL_RTW_DIS  = 2;   // write 1 disarms reset-time wd
	localparam int CTRL_POL_LSB  = 4;   // two policy bits

	// ------------------------------------------------------------
	// command fields (write-only pulses)
	// ------------------------------------------------------------
	localparam int CMD_DIS_BOOT  = 0;   // boot cpu failed self-test
	localparam int CMD_DIS_SEC   = 1;   // secondary cpu failed
	localparam int CMD_RETEST    = 2;   // clear history of slot
	localparam int CMD_SLOT_LSB  = 8;   // target slot field

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [31:0] RTW_LOAD_RST = 32'h0000_1000;
	localparam logic [31:0] SCW_LOAD_RST = 32'h0000_4000;
	localparam logic [31:0] OSW_LOAD_RST = 32'h0000_8000;
	localparam logic [1:0]  FAIL_LIMIT   = 2'h3; // completion failures since reset or retest
	localparam int          TICK_NS      = 1000; // timebase tick, ns
	localparam int          CLK_NS       = 25;   // 40 MHz clock
	localparam int          TICK_CYC     = TICK_NS / CLK_NS;

	// completion failure policy
	typedef enum logic [1:0] {
		POL_NEXT  = 2'h0,   // disable on next reboot
		POL_NEVER = 2'h1,   // never disable
		POL_THREE = 2'h2    // disable after three failures since reset or retest
	} policy_t;

	// slot report states
	typedef enum logic [1:0] {
		SLOT_ABSENT = 2'h0,
		SLOT_PASSED = 2'h1,
		SLOT_FAILED = 2'h2
	} slot_state_t;

endpackage

/* shared/wd_if.sv */
`timescale 1ns/1ps
// watchdog control and status bundle
interface wd_if;
	logic        arm;      // count while high
	logic        restart;  // reload from load value
	logic [31:0] load;     // timeout in ticks
	logic        expire;   // one-cycle pulse on zero
	logic        running;  // counting
	modport ctl (output arm, output restart, output load,
		input expire, input running);
	modport wd  (input arm, input restart, input load,
		output expire, output running);
endinterface

/* logic/wd_counter.sv */
`timescale 1ns/1ps
// one down-counting watchdog, ticks from a shared timebase
module wd_counter (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic tick,
	wd_if.wd          w
);
	import frb_pkg::*;

	logic [31:0] cnt_q;    // remaining ticks
	logic        run_q;    // armed and loaded

	// ------------------------------------------------------------
	// count: disarm acts at once, expiry on reaching zero
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 32'h0;
			run_q <= 1'b0;
		end else if (!w.arm) begin
			run_q <= 1'b0;               // [R22]
		end else if (w.restart || !run_q) begin
			cnt_q <= w.load;
			run_q <= 1'b1;
		end else if (tick && cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;      // [R22]
		end
	end

	// pulse in the cycle the count reaches zero
	assign w.expire  = w.arm && run_q && !w.restart && tick &&
		cnt_q == 32'h1;                 // [R22]
	assign w.running = run_q;

	a_expire_zero: assert property ( // [R22]
		@(posedge clk) disable iff (!rstn)
		w.expire |=> cnt_q == 32'h0) else $error("count not zero");
endmodule // wd_counter

/* logic/frb_timebase.sv */
`timescale 1ns/1ps
// divides the clock down to the watchdog tick
module frb_timebase #(
	parameter int DIV = frb_pkg::TICK_CYC
) (
	input  wire logic clk,
	input  wire logic rstn,
	output logic      tick
);
	logic [15:0] div_q;    // cycle count within one tick

	// ------------------------------------------------------------
	// free running divider
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_q <= 16'h0;
		else if (div_q == 16'(DIV - 1))
			div_q <= 16'h0;
		else
			div_q <= div_q + 16'h1;
	end

	assign tick = (div_q == 16'(DIV - 1));
endmodule // frb_timebase

/* logic/fault_resilient_boot_watchdog.sv */
// ------------------------------------------------------------
// Overview of operation
// R1: two watchdogs; reset-time one starts after hard reset
// R2: firmware disarms reset-time watchdog before expiry
// R3: reset-time expiry resets system, disables boot cpu
// R4: pick next boot cpu each expiry until disarmed
// R5: beep when no working cpu, keep cycling
// R6: soft reset leaves reset-time watchdog alone
// R7: firmware arms completion watchdog before disarming first
// R8: firmware extends, then disarms completion watchdog
// R9: firmware disarms completion watchdog before password
// R10: completion expiry issues async system reset
// R11: retain failing cpu status after completion reset
// R12: completion policy: next, never, or three failures
// R13: self-test failure request disables, reselects, resets
// R14: no alternate cpu: beep and halt
// R15: os load watchdog, off by default, reboots
// R16: secondary cpu disable request disables it
// R17: log reset-time failures by itself
// R18: nonvolatile failure history until retest
// R19: all bad: keep original boot cpu
// R20: terminator fitted clears slot failure flag
// R21: each slot reports passed, failed, or absent
// R22: tick decrement, expire at zero, instant disarm
// ------------------------------------------------------------
`timescale 1ns/1ps
module fault_resilient_boot_watchdog #(
	parameter int NCPU = 2                  // processor slots
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              hard_reset_n,  // hard reset / power
	input  wire logic              soft_reset,    // soft reset seen
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [31:0]            rdata,
	input  wire logic [NCPU-1:0]   cpu_present,   // socket populated
	input  wire logic [NCPU-1:0]   terminator,    // terminator fitted
	input  wire logic [NCPU-1:0]   nv_hist_in,    // history load value
	output logic [NCPU-1:0]        nv_hist_out,   // history to store
	output logic                   nv_hist_wr,    // store strobe
	output logic                   sys_reset,     // system reset pulse
	output logic                   async_system_reset, // completion reset
	output logic [NCPU-1:0]        cpu_disable,   // disabled cpus
	output logic [NCPU-1:0]        primary_boot_cpu, // one-hot boot cpu
	output logic                   beep,          // speaker request
	output logic                   halt           // stop the system
);
	import frb_pkg::*;

	localparam int SW = $clog2(NCPU) > 0 ? $clog2(NCPU) : 1;

	// ------------------------------------------------------------
	// shared timebase and three watchdogs
	// ------------------------------------------------------------
	logic tick;                 // one per tick period
	wd_if rtw ();               // reset-time watchdog
	wd_if scw ();               // selftest completion watchdog
	wd_if osw ();               // os load watchdog

	frb_timebase u_tb (.clk(clk), .rstn(rstn), .tick(tick));
	wd_counter u_rtw (.clk(clk), .rstn(rstn), .tick(tick), .w(rtw));
	wd_counter u_scw (.clk(clk), .rstn(rstn), .tick(tick), .w(scw));
	wd_counter u_osw (.clk(clk), .rstn(rstn), .tick(tick), .w(osw));

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0]     rtw_load_q, scw_load_q, osw_load_q; // timeouts
	logic            rtw_arm_q;     // reset-time wd armed
	logic            rtw_rst_q;     // reload request
	logic            scw_arm_q;     // completion wd armed
	logic            osw_arm_q;     // os wd armed, off by default
	policy_t         pol_q;         // completion failure policy
	logic [SW-1:0]   boot_q;        // current boot cpu
	logic [SW-1:0]   orig_q;        // boot cpu before cycling
	logic [NCPU-1:0] fail_q;        // failure history, nonvolatile copy
	logic [NCPU-1:0] scw_flag_q;    // retained completion status
	logic [1:0]      scw_cnt_q;     // completion failures since reset or retest
	logic            hist_ld_q;     // history loaded after reset
	logic            hr_q;          // hard_reset_n level seen last cycle
	logic [7:0]      log_q;         // self-logged event count
	logic            beep_q, halt_q;
	logic            sysrst_q, asr_q;

	// command decode
	logic            wr_ctrl, wr_cmd;
	logic [SW-1:0]   cmd_slot;
	logic            hard_rel;      // hard reset release pulse
	assign wr_ctrl  = wr && addr == OFF_CTRL;
	assign wr_cmd   = wr && addr == OFF_CMD;
	assign cmd_slot = wdata[CMD_SLOT_LSB +: SW];
	assign hard_rel = hard_reset_n && !hr_q;

	// ------------------------------------------------------------
	// next good cpu search, wraps around from the current one
	// ------------------------------------------------------------
	logic [SW-1:0] next_cpu;     // candidate after boot_q
	logic          next_ok;      // a good candidate exists
	always_comb begin
		next_cpu = boot_q;
		next_ok  = 1'b0;
		for (int i = NCPU - 1; i >= 1; i--) begin
			if (cpu_present[(int'(boot_q) + i) % NCPU] &&
				!fail_q[(int'(boot_q) + i) % NCPU]) begin
				next_cpu = SW'((int'(boot_q) + i) % NCPU);
				next_ok  = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// watchdog drive
	// ------------------------------------------------------------
	assign rtw.arm     = rtw_arm_q;
	assign rtw.restart = rtw_rst_q;
	assign rtw.load    = rtw_load_q;
	assign scw.arm     = scw_arm_q;
	assign scw.restart = wr_ctrl && wdata[CTRL_SCW_ARM] && scw_arm_q; // [R8]
	assign scw.load    = scw_load_q;
	assign osw.arm     = osw_arm_q;
	assign osw.restart = 1'b0;
	assign osw.load    = osw_load_q;

	// ------------------------------------------------------------
	// hard reset edge tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hr_q <= 1'b0;
		else
			hr_q <= hard_reset_n;
	end

	// ------------------------------------------------------------
	// reset-time watchdog arming; soft reset is not an input here
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rtw_arm_q <= 1'b0;
			rtw_rst_q <= 1'b0;
		end else begin
			rtw_rst_q <= 1'b0;
			if (hard_rel || rtw.expire) begin
				rtw_arm_q <= 1'b1;           // [R1] [R4]
				rtw_rst_q <= 1'b1;
			end else if (wr_ctrl && wdata[CTRL_RTW_DIS]) begin
				rtw_arm_q <= 1'b0;           // [R2]
			end
		end
	end

	// ------------------------------------------------------------
	// firmware control and timeouts
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scw_arm_q  <= 1'b0;
			osw_arm_q  <= 1'b0;                  // [R15]
			pol_q      <= POL_NEXT;              // [R12]
			rtw_load_q <= RTW_LOAD_RST;          // [R6]
			scw_load_q <= SCW_LOAD_RST;
			osw_load_q <= OSW_LOAD_RST;
		end else begin
			if (scw.expire)
				scw_arm_q <= 1'b0;
			else if (wr_ctrl)
				scw_arm_q <= wdata[CTRL_SCW_ARM];
			if (osw.expire)
				osw_arm_q <= 1'b0;
			else if (wr_ctrl)
				osw_arm_q <= wdata[CTRL_OSW_ARM];    // [R15]
			if (wr_ctrl) begin
				case (wdata[CTRL_POL_LSB +: 2])
					2'h1:    pol_q <= POL_NEVER;
					2'h2:    pol_q <= POL_THREE;
					default: pol_q <= POL_NEXT;
				endcase
			end
			if (wr && addr == OFF_RTW_LOAD) rtw_load_q <= wdata;
			if (wr && addr == OFF_SCW_LOAD) scw_load_q <= wdata;
			if (wr && addr == OFF_OSW_LOAD) osw_load_q <= wdata;
		end
	end

	// ------------------------------------------------------------
	// boot cpu selection, failure history, retained status
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_q     <= '0;
			orig_q     <= '0;
			fail_q     <= '0;
			scw_flag_q <= '0;
			scw_cnt_q  <= 2'h0;
			hist_ld_q  <= 1'b0;
			beep_q     <= 1'b0;
			halt_q     <= 1'b0;
			log_q      <= 8'h0;
		end else begin
			beep_q <= 1'b0;
			if (!hist_ld_q) begin
				fail_q    <= nv_hist_in;        // [R18]
				hist_ld_q <= 1'b1;
			end else if (hard_rel) begin
				fail_q <= fail_q & ~terminator; // [R20]
				orig_q <= boot_q;
				halt_q <= 1'b0;
			end else if (rtw.expire) begin
				fail_q[boot_q] <= 1'b1;         // [R3]
				log_q <= log_q + 8'h1;          // [R17]
				if (next_ok)
					boot_q <= next_cpu;         // [R4]
				else begin
					boot_q <= orig_q;           // [R19]
					beep_q <= 1'b1;             // [R5]
				end
			end else if (scw.expire) begin
				scw_flag_q[boot_q] <= 1'b1;     // [R11]
				scw_cnt_q <= (scw_cnt_q == FAIL_LIMIT) ? scw_cnt_q
					: scw_cnt_q + 2'h1;
				if (pol_q == POL_NEXT ||
					(pol_q == POL_THREE &&
					scw_cnt_q + 2'h1 == FAIL_LIMIT))
					fail_q[boot_q] <= 1'b1;     // [R12]
			end else if (wr_cmd && wdata[CMD_DIS_BOOT]) begin
				fail_q[boot_q] <= 1'b1;         // [R13]
				if (next_ok)
					boot_q <= next_cpu;         // [R13]
				else begin
					beep_q <= 1'b1;             // [R14]
					halt_q <= 1'b1;             // [R14]
				end
			end else if (wr_cmd && wdata[CMD_DIS_SEC]) begin
				fail_q[cmd_slot] <= 1'b1;       // [R16]
			end else if (wr_cmd && wdata[CMD_RETEST]) begin
				fail_q[cmd_slot]     <= 1'b0;   // [R18]
				scw_flag_q[cmd_slot] <= 1'b0;
				scw_cnt_q            <= 2'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// reset outputs, one pulse each
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sysrst_q <= 1'b0;
			asr_q    <= 1'b0;
		end else begin
			sysrst_q <= rtw.expire || osw.expire ||
				(wr_cmd && wdata[CMD_DIS_BOOT] && next_ok); // [R3] [R13]
			asr_q    <= scw.expire;             // [R10]
		end
	end

	// history store strobe when the copy changes
	logic [NCPU-1:0] fail_d1_q;   // last stored value
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fail_d1_q <= '0;
		else
			fail_d1_q <= fail_q;
	end

	// ------------------------------------------------------------
	// slot report: passed, failed or absent
	// ------------------------------------------------------------
	logic [2*NCPU-1:0] slots;     // two bits per slot
	always_comb begin
		for (int i = 0; i < NCPU; i++) begin
			if (!cpu_present[i] || terminator[i])
				slots[2*i +: 2] = SLOT_ABSENT;  // [R21]
			else if (fail_q[i])
				slots[2*i +: 2] = SLOT_FAILED;
			else
				slots[2*i +: 2] = SLOT_PASSED;
		end
	end

	// ------------------------------------------------------------
	// register read, data the cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata <= 32'h0;
		else if (rd) begin
			case (addr)
				OFF_CTRL:     rdata <= {26'h0, pol_q, 1'b0, rtw_arm_q,
					osw_arm_q, scw_arm_q};
				OFF_RTW_LOAD: rdata <= rtw_load_q;
				OFF_SCW_LOAD: rdata <= scw_load_q;
				OFF_OSW_LOAD: rdata <= osw_load_q;
				OFF_STATUS:   rdata <= 32'({scw_cnt_q, halt_q,
					scw_flag_q, 8'(boot_q)});
				OFF_SLOTS:    rdata <= 32'(slots);
				OFF_HIST:     rdata <= 32'(fail_q);
				OFF_LOG:      rdata <= {24'h0, log_q};
				default:      rdata <= 32'h0;
			endcase
		end else
			rdata <= 32'h0;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		primary_boot_cpu = '0;
		primary_boot_cpu[boot_q] = 1'b1;
	end
	assign cpu_disable        = fail_q & ~primary_boot_cpu;
	assign nv_hist_out        = fail_q;
	assign nv_hist_wr         = hist_ld_q && fail_q != fail_d1_q;
	assign sys_reset          = sysrst_q;
	assign async_system_reset = asr_q;
	assign beep               = beep_q;
	assign halt               = halt_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// reset-time expiry answers with a reset pulse beside a reload
	sequence rtw_fired;
		rtw.expire;
	endsequence
	sequence rtw_reload;
		rtw_rst_q ##1 rtw.running;
	endsequence
	a_rtw_reset: assert property ( // [R3]
		@(posedge clk) disable iff (!rstn)
		rtw_fired |=> sys_reset) else $error("no reset");
	a_rtw_rearm: assert property ( // [R4]
		@(posedge clk) disable iff (!rstn)
		rtw_fired |=> rtw_reload) else $error("not rearmed");
	a_scw_asr: assert property ( // [R10]
		@(posedge clk) disable iff (!rstn)
		scw.expire |=> async_system_reset) else $error("no asr");
	// a failure bit only drops on a retest or a terminator at hard reset
	a_hist_keep: assert property ( // [R18]
		@(posedge clk) disable iff (!rstn)
		hist_ld_q && !hard_rel && !(wr_cmd && wdata[CMD_RETEST])
		|=> (fail_q & $past(fail_q)) == $past(fail_q))
		else $error("history bit lost");
	a_osw_off: assert property ( // [R15]
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> !osw_arm_q) else $error("os wd on");
	a_halt_beep: assert property ( // [R14]
		@(posedge clk) disable iff (!rstn)
		$rose(halt_q) |-> beep_q) else $error("halt without beep");
	a_soft_quiet: assert property ( // [R6]
		@(posedge clk) disable iff (!rstn)
		soft_reset && !hard_rel && !rtw.expire |=> !rtw_rst_q)
		else $error("soft reset reloaded");
	a_retain_flag: assert property ( // [R11]
		@(posedge clk) disable iff (!rstn)
		scw.expire && hist_ld_q && !hard_rel && !rtw.expire
		|=> scw_flag_q[boot_q]) else $error("flag lost");
endmodule // fault_resilient_boot_watchdog

/* test/host_fw.sv */
`timescale 1ns/1ps
// stand-in for the host boot firmware, owns the register port
module host_fw
	import frb_pkg::*;
(
	input  wire logic   clk,
	output logic [3:0]  addr,
	output logic [31:0] wdata,
	output logic        wr,
	output logic        rd
);
	// ----------------------------------------
	// idle port at time zero
	// ----------------------------------------
	initial begin
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one write cycle; wdata is inverted outside it, so a late look shows
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// one read cycle; the bench takes the answer in the next cycle
	task automatic get(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// good boot: no gap in supervision, extend, then stand down
	task automatic boot_ok();
		put(OFF_CTRL, 32'h1 << CTRL_SCW_ARM);
		put(OFF_CTRL, (32'h1 << CTRL_SCW_ARM) | (32'h1 << CTRL_RTW_DIS));
		put(OFF_CTRL, 32'h1 << CTRL_SCW_ARM);
		put(OFF_CTRL, 32'h0);
	endtask
endmodule // host_fw

/* test/fault_resilient_boot_watchdog_bench.sv */
`timescale 1ns/1ps
module fault_resilient_boot_watchdog_bench;
	import frb_pkg::*;
	// ----------------------------------------
	// nets and bench state
	// ----------------------------------------
	logic        clk;          // 40 MHz
	logic        rstn;         // async, low active
	logic        hard_reset_n; // host hard reset
	logic        soft_reset;   // host soft reset
	logic [3:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [1:0]  nv_hist_out;
	logic        nv_hist_wr;
	logic        sys_reset;
	logic        async_system_reset;
	logic [1:0]  cpu_disable;
	logic [1:0]  primary_boot_cpu;
	logic        beep;
	logic        halt;
	logic [1:0]  present;      // populated sockets
	logic [1:0]  term;         // terminator modules fitted
	logic [31:0] notes[$];     // expected read data, oldest first
	logic        rd_q;         // read strobe one cycle ago
	logic [7:0]  lfsr;         // random source
	int          mismatches;
	int          checked;
	int          cyc;          // timeout count
	int          n;            // random timeout in ticks
	int          c;
	int          t;
	localparam logic [31:0] POL_W = 32'(POL_NEVER) << CTRL_POL_LSB;

	host_fw u_fw (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	fault_resilient_boot_watchdog #(.NCPU(2)) u_dut (
		.clk(clk), .rstn(rstn), .hard_reset_n(hard_reset_n),
		.soft_reset(soft_reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .cpu_present(present), .terminator(term),
		.nv_hist_in(2'h0), .nv_hist_out(nv_hist_out),
		.nv_hist_wr(nv_hist_wr), .sys_reset(sys_reset),
		.async_system_reset(async_system_reset),
		.cpu_disable(cpu_disable), .primary_boot_cpu(primary_boot_cpu),
		.beep(beep), .halt(halt));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// read with a note of the expected answer
	task automatic get(input logic [3:0] a, input logic [31:0] exp);
		notes.push_back(exp);
		u_fw.get(a);
	endtask
	// let the edge's updates land before looking
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait: sel 0 sys_reset, 1 async reset, 2 halt, 3 beep
	task automatic await(input int sel, input int lim, output int k);
		logic [3:0] ev;
		k = 0;
		#1;
		ev = {beep, halt, async_system_reset, sys_reset};
		while (k < lim && ev[sel] !== 1'b1) begin
			step(1);
			k++;
			ev = {beep, halt, async_system_reset, sys_reset};
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// clock, read monitor and timeout
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		cyc <= cyc + 1;
		if (rd_q === 1'b1)
			check("rdata", rdata, notes.pop_front());
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		hard_reset_n = 1'b0;
		soft_reset = 1'b0;
		present = 2'h3;
		term = 2'h0;
		rd_q = 1'b0;
		cyc = 0;
		mismatches = 0;
		checked = 0;
		lfsr = 8'h36;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		step(2);
		check("boot cpu", 32'(primary_boot_cpu), 32'h1);
		get(OFF_RTW_LOAD, RTW_LOAD_RST);
		get(4'hf, 32'h0);
		// short random reset-time timeout, then leave hard reset
		lfsr = nxt(lfsr);
		n = 2 + int'(lfsr[1:0]);
		u_fw.put(OFF_RTW_LOAD, 32'(n));
		@(posedge clk);
		hard_reset_n <= 1'b1;
		t = n * TICK_CYC / 2;
		step(t);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		await(0, n * TICK_CYC, c);
		t = t + 2 + c;
		check("rtw time", 32'(t >= (n - 1) * TICK_CYC &&
			t <= n * TICK_CYC + 4), 32'h1);
		check("boot cpu", 32'(primary_boot_cpu), 32'h2);
		check("disable", 32'(cpu_disable), 32'h1);
		get(OFF_LOG, 32'h1);
		// firmware takes over: cycling must stop
		u_fw.boot_ok();
		await(0, 3 * n * TICK_CYC, c);
		check("rtw stopped", 32'(c), 32'(3 * n * TICK_CYC));
		// completion watchdog runs out under the never policy
		u_fw.put(OFF_SCW_LOAD, 32'h2);
		u_fw.put(OFF_CTRL, POL_W | (32'h1 << CTRL_SCW_ARM));
		await(1, 3 * TICK_CYC, c);
		check("scw time", 32'(c >= TICK_CYC - 2 &&
			c <= 2 * TICK_CYC + 4), 32'h1);
		check("boot cpu", 32'(primary_boot_cpu), 32'h2);
		check("history", 32'(nv_hist_out), 32'h1);
		get(OFF_STATUS, 32'h0000_0a01);
		u_fw.put(OFF_CTRL, POL_W);
		// os load watchdog reboots when left armed
		u_fw.put(OFF_OSW_LOAD, 32'h2);
		u_fw.put(OFF_CTRL, POL_W | (32'h1 << CTRL_OSW_ARM));
		await(0, 3 * TICK_CYC, c);
		check("osw time", 32'(c >= TICK_CYC - 2 &&
			c <= 2 * TICK_CYC + 4), 32'h1);
		u_fw.put(OFF_CTRL, POL_W | (32'h1 << CTRL_RTW_DIS));
		// boot cpu fails self-test with no good cpu left
		u_fw.put(OFF_CMD, (32'h1 << CMD_DIS_BOOT) | (32'h1 << CMD_SLOT_LSB));
		await(3, 20, c);
		check("beep", 32'(beep), 32'h1);
		check("halt", 32'(halt), 32'h1);
		get(OFF_SLOTS, {28'h0, SLOT_FAILED, SLOT_FAILED});
		step(2);
		check("history", 32'(nv_hist_out), 32'h3);
		// retest clears one slot, a secondary disable marks it again
		u_fw.put(OFF_CMD, 32'h1 << CMD_RETEST);
		#1;
		check("store", 32'(nv_hist_wr), 32'h1);
		check("history", 32'(nv_hist_out), 32'h2);
		u_fw.put(OFF_CMD, 32'h1 << CMD_DIS_SEC);
		#1;
		check("history", 32'(nv_hist_out), 32'h3);
		// terminator in slot 1 over a hard reset clears its flag
		@(posedge clk);
		term <= 2'h2;
		hard_reset_n <= 1'b0;
		@(posedge clk);
		hard_reset_n <= 1'b1;
		step(2);
		check("history", 32'(nv_hist_out), 32'h1);
		get(OFF_SLOTS, {28'h0, SLOT_ABSENT, SLOT_FAILED});
		// no good cpu left: beep, keep the boot cpu of the hard reset
		await(3, 3 * n * TICK_CYC, c);
		check("beep", 32'(beep), 32'h1);
		check("boot cpu", 32'(primary_boot_cpu), 32'h2);
		conclude();
	end
endmodule // fault_resilient_boot_watchdog_bench
